/* src/uhcc_map.svh */
`ifndef UHCC_MAP_SVH
`define UHCC_MAP_SVH

`define UHCC_CODE_RD_MODE 8'h01
`define UHCC_CODE_RD_CMD 8'h02
`define UHCC_CODE_WR_MODE 8'h81
`define UHCC_CODE_WR_CMD 8'h82

`define UHCC_BIT_WAKE_EN 10
`define UHCC_BIT_WAKE_CONN 9
`define UHCC_FS_HI 7
`define UHCC_FS_LO 6
`define UHCC_BIT_HC_RESET 0
`define UHCC_SOC_HI 17
`define UHCC_SOC_LO 16

`define UHCC_SOC_RESET 2'h0
`define UHCC_SOC_ONE 2'h1
`define UHCC_WORD_ZERO 32'h0000_0000

`define UHCC_SOF_DELAY_NS 1000000
`define UHCC_CLK_PERIOD_NS 10

`endif

/* src/uhcc_pkg.sv */
package uhcc_pkg;
    typedef enum logic [1:0] {
        UHCC_BUS_RESET_STATE = 2'b00,
        UHCC_RESUME_STATE = 2'b01,
        UHCC_OPERATIONAL_STATE = 2'b10,
        UHCC_SUSPEND_STATE = 2'b11
    } uhcc_fstate_t;
endpackage : uhcc_pkg

/* src/uhcc_delay_timer.sv */
`timescale 1ns/1ps
module uhcc_delay_timer #(
    parameter int unsigned CYCLES = 100000,
    parameter int unsigned CW = 17
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic abort,
    output logic done
);
    if (CYCLES < 1 || CYCLES >= (64'd1 << CW)) begin : g_bad_cycles
        $error("uhcc_delay_timer: CYCLES does not fit CW");
    end

    logic [CW-1:0] cnt_ff;
    logic run_ff;
    wire last = run_ff && (cnt_ff == CW'(CYCLES - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else begin
            if (abort || start) begin
                cnt_ff <= '0;
                run_ff <= start && !abort;
            end else if (last) begin
                run_ff <= 1'b0;
            end else if (run_ff) begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
    end

    // Unregistered so the caller's flop lands exactly CYCLES edges after start
    assign done = last && !abort && !start;
endmodule : uhcc_delay_timer

/* src/uhcc_regs.sv */
`timescale 1ns/1ps
`include "uhcc_map.svh"
module uhcc_regs #(
    parameter int unsigned SOF_DELAY_CYCLES = `UHCC_SOF_DELAY_NS / `UHCC_CLK_PERIOD_NS,
    parameter int unsigned SOF_CW = 17
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    input wire logic resume_signal,
    input wire logic resume_seen_flag,
    input wire logic periodic_overrun,
    output logic [31:0] rd_data_ff,
    output logic rd_valid_ff,
    output logic remote_wakeup_ff,
    output logic resume_event_ff,
    output logic frame_start_flag_ff,
    output logic periodic_overrun_flag_ff,
    output logic sof_enable_ff,
    output logic root_hub_reset_ff,
    output logic port_reset_ff,
    output logic [1:0] functional_state_ff
);
    // Refuse a delay the timer cannot count
    if (SOF_DELAY_CYCLES < 1 || SOF_DELAY_CYCLES >= (64'd1 << SOF_CW)) begin : g_bad_delay
        $error("uhcc_regs: SOF_DELAY_CYCLES must be at least one and fit SOF_CW");
    end

    logic remote_wake_enable_ff;
    logic remote_wake_connected_ff;
    logic hc_reset_req_ff;
    logic [1:0] periodic_overrun_counter_ff;
    logic sof_done;

    // Decode of the command codes
    wire wr_mode = cmd_valid && (cmd_code == `UHCC_CODE_WR_MODE);
    wire wr_cmd = cmd_valid && (cmd_code == `UHCC_CODE_WR_CMD);
    wire rd_mode = cmd_valid && (cmd_code == `UHCC_CODE_RD_MODE);
    wire rd_cmd = cmd_valid && (cmd_code == `UHCC_CODE_RD_CMD);

    // Software reset runs the cycle after the request bit is seen
    wire sw_reset = hc_reset_req_ff;

    wire [1:0] wr_fs = cmd_wdata[`UHCC_FS_HI:`UHCC_FS_LO];
    wire fs_suspended = functional_state_ff == uhcc_pkg::UHCC_SUSPEND_STATE;
    // Host write wins over a resume seen in the same cycle
    wire hw_resume = fs_suspended && resume_signal && !wr_mode && !sw_reset;

    logic [1:0] nxt_functional_state;
    always_comb begin
        nxt_functional_state = functional_state_ff;
        if (sw_reset) begin
            nxt_functional_state = uhcc_pkg::UHCC_BUS_RESET_STATE;
        end else if (wr_mode) begin
            nxt_functional_state = wr_fs;
        end else if (hw_resume) begin
            nxt_functional_state = uhcc_pkg::UHCC_RESUME_STATE;
        end
    end

    wire nxt_oper = nxt_functional_state == uhcc_pkg::UHCC_OPERATIONAL_STATE;
    wire now_oper = functional_state_ff == uhcc_pkg::UHCC_OPERATIONAL_STATE;
    wire enter_oper = nxt_oper && !now_oper;
    wire leave_oper = !nxt_oper;

    // Only one frame-start delay; leaving operational abandons it
    uhcc_delay_timer #(
        .CYCLES(SOF_DELAY_CYCLES),
        .CW(SOF_CW)
    ) u_sof_delay (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(enter_oper),
        .abort(leave_oper),
        .done(sof_done)
    );

    // Read mux, reserved bits as zero
    wire [31:0] mode_word = {21'h0, remote_wake_enable_ff, remote_wake_connected_ff, 1'b0,
        functional_state_ff, 6'h0};
    wire [31:0] cmd_word = {14'h0, periodic_overrun_counter_ff, 15'h0,
        hc_reset_req_ff};
    wire [31:0] nxt_rd_data = rd_mode ? mode_word :
        (rd_cmd ? cmd_word : `UHCC_WORD_ZERO);

    // One answer cycle per read code
    wire nxt_rd_valid = rd_mode || rd_cmd;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // Data idles at zero so a stale word never looks like an answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= `UHCC_WORD_ZERO;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            functional_state_ff <= uhcc_pkg::UHCC_BUS_RESET_STATE;
        end else begin
            functional_state_ff <= nxt_functional_state;
        end
    end

    // Only a hardware reset or a mode write clears it; software reset leaves it alone
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            remote_wake_connected_ff <= 1'b0;
        end else if (wr_mode) begin
            // Firmware is expected to set this during self test
            remote_wake_connected_ff <= cmd_wdata[`UHCC_BIT_WAKE_CONN];
        end
    end

    // Host write wins over a software reset in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            remote_wake_enable_ff <= 1'b0;
        end else if (wr_mode) begin
            remote_wake_enable_ff <= cmd_wdata[`UHCC_BIT_WAKE_EN];
        end else if (sw_reset) begin
            remote_wake_enable_ff <= 1'b0;
        end
    end

    // Write-to-set; a new request wins over the completion clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hc_reset_req_ff <= 1'b0;
        end else if (wr_cmd && cmd_wdata[`UHCC_BIT_HC_RESET]) begin
            hc_reset_req_ff <= 1'b1;
        end else if (sw_reset) begin
            hc_reset_req_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            periodic_overrun_flag_ff <= 1'b0;
        end else begin
            periodic_overrun_flag_ff <= periodic_overrun;
        end
    end

    // Counter is read-only to the host; writes of its bits are ignored
    // Increment wins over a software reset so no overrun is lost
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            periodic_overrun_counter_ff <= `UHCC_SOC_RESET;
        end else if (periodic_overrun) begin
            periodic_overrun_counter_ff <= periodic_overrun_counter_ff + `UHCC_SOC_ONE;
        end else if (sw_reset) begin
            periodic_overrun_counter_ff <= `UHCC_SOC_RESET;
        end
    end

    // Wake output, one cycle behind the flag
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            remote_wakeup_ff <= 1'b0;
        end else begin
            remote_wakeup_ff <= remote_wake_enable_ff && resume_seen_flag;
        end
    end

    // The resume event itself never looks at the enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resume_event_ff <= 1'b0;
        end else begin
            resume_event_ff <= hw_resume;
        end
    end

    // Timer done is already masked by a leave in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frame_start_flag_ff <= 1'b0;
        end else begin
            frame_start_flag_ff <= sof_done;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sof_enable_ff <= 1'b0;
        end else if (leave_oper) begin
            sof_enable_ff <= 1'b0;
        end else if (sof_done) begin
            sof_enable_ff <= 1'b1;
        end
    end

    // Software reset leaves root hub and ports alone
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            root_hub_reset_ff <= 1'b1;
        end else begin
            root_hub_reset_ff <= 1'b0;
        end
    end

    // Port reset signalling lasts until the host picks a working state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_reset_ff <= 1'b1;
        end else if (wr_mode && wr_fs != uhcc_pkg::UHCC_BUS_RESET_STATE) begin
            port_reset_ff <= 1'b0;
        end
    end
endmodule : uhcc_regs

/* dv/uhcc_regs_asserts.sv */
`timescale 1ns/1ps
module uhcc_regs_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic periodic_overrun,
    input wire logic resume_seen_flag,
    input wire logic [31:0] rd_data_ff,
    input wire logic rd_valid_ff,
    input wire logic remote_wakeup_ff,
    input wire logic resume_event_ff,
    input wire logic frame_start_flag_ff,
    input wire logic periodic_overrun_flag_ff,
    input wire logic sof_enable_ff,
    input wire logic [1:0] functional_state_ff
);
    wire logic rd_cmd = cmd_valid && (cmd_code == 8'h01 || cmd_code == 8'h02);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (rd_cmd |=> rd_valid_ff) else $error("read lost");
    a_no_stray: assert property (!rd_cmd |=> !rd_valid_ff) else $error("stray read");
    a_rsv_zero: assert property (rd_valid_ff |-> (rd_data_ff & 32'hfffc_f93e) == 32'h0)
        else $error("reserved bit set");
    a_wake_cause: assert property (remote_wakeup_ff |-> $past(resume_seen_flag))
        else $error("wake without cause");
    a_ovr_pulse: assert property (periodic_overrun |=> periodic_overrun_flag_ff)
        else $error("overrun lost");
    a_ovr_only: assert property (!periodic_overrun |=> !periodic_overrun_flag_ff)
        else $error("stray overrun");
    a_resume_move: assert property (resume_event_ff |-> functional_state_ff == 2'h1 &&
        $past(functional_state_ff) == 2'h3) else $error("bad resume");
    a_frame_start: assert property (frame_start_flag_ff |-> sof_enable_ff &&
        functional_state_ff == 2'h2) else $error("bad frame start");
    a_sof_stop: assert property (functional_state_ff != 2'h2 |=> !sof_enable_ff)
        else $error("frames outside operational");
    cover property (frame_start_flag_ff);
    cover property (resume_event_ff);
    cover property (periodic_overrun_flag_ff);
endmodule : uhcc_regs_asserts
bind uhcc_regs uhcc_regs_asserts u_chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .periodic_overrun(periodic_overrun),
    .resume_seen_flag(resume_seen_flag),
    .rd_data_ff(rd_data_ff),
    .rd_valid_ff(rd_valid_ff),
    .remote_wakeup_ff(remote_wakeup_ff),
    .resume_event_ff(resume_event_ff),
    .frame_start_flag_ff(frame_start_flag_ff),
    .periodic_overrun_flag_ff(periodic_overrun_flag_ff),
    .sof_enable_ff(sof_enable_ff),
    .functional_state_ff(functional_state_ff)
);

/* dv/uhcc_host_model.sv */
`timescale 1ns/1ps
module uhcc_host_model (
    input wire logic clk_sys,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [31:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 32'h0;
    end
    task automatic issue(input logic [7:0] code, input logic [31:0] data);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        // Released bus flips, so stale data cannot pass
        cmd_wdata = ~data;
    endtask : issue
endmodule : uhcc_host_model

/* dv/usb_host_control_command_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module usb_host_control_command_regs_tb;
    localparam int unsigned SOF = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic resume_signal = 1'b0;
    logic resume_seen_flag = 1'b0;
    logic periodic_overrun = 1'b0;
    logic cmd_valid, rd_valid_ff, remote_wakeup_ff, frame_start_flag_ff, sof_enable_ff;
    logic resume_event_ff, root_hub_reset_ff, port_reset_ff;
    logic [7:0] cmd_code;
    logic [31:0] cmd_wdata, rd_data_ff;
    int num_errors = 0;
    int num_checks = 0;
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    uhcc_host_model host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata));
    uhcc_regs #(.SOF_DELAY_CYCLES(SOF)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .resume_signal(resume_signal), .resume_seen_flag(resume_seen_flag),
        .periodic_overrun(periodic_overrun), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .remote_wakeup_ff(remote_wakeup_ff), .resume_event_ff(resume_event_ff),
        .frame_start_flag_ff(frame_start_flag_ff), .periodic_overrun_flag_ff(),
        .sof_enable_ff(sof_enable_ff), .root_hub_reset_ff(root_hub_reset_ff),
        .port_reset_ff(port_reset_ff),
        .functional_state_ff());
    task automatic rd(input logic [7:0] code, input logic [31:0] exp);
        host.issue(code, 32'h0);
        `CHK(rd_valid_ff, 1'b1)
        `CHK(rd_data_ff, exp)
    endtask : rd
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        `CHK(root_hub_reset_ff, 1'b1)
        `CHK(port_reset_ff, 1'b1)
        rst_n = 1'b1;
        rd(8'h01, 32'h0);
        rd(8'h02, 32'h0);
        `CHK(root_hub_reset_ff, 1'b0)
        `CHK(port_reset_ff, 1'b1)
    endtask : do_reset
    task automatic check_mode_write;
        host.issue(8'h81, 32'hffff_ffff);
        rd(8'h01, 32'h0000_06c0);
    endtask : check_mode_write
    task automatic check_resume;
        resume_seen_flag = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(remote_wakeup_ff, 1'b1)
        resume_seen_flag = 1'b0;
        resume_signal = 1'b1;
        @(negedge clk_sys);
        `CHK(resume_event_ff, 1'b1)
        resume_signal = 1'b0;
        rd(8'h01, 32'h0000_0640);
    endtask : check_resume
    task automatic check_wake_off;
        // Suspend with wake enable clear; the event must still come
        host.issue(8'h81, 32'h0000_00c0);
        resume_seen_flag = 1'b1;
        resume_signal = 1'b1;
        @(negedge clk_sys);
        `CHK(resume_event_ff, 1'b1)
        `CHK(remote_wakeup_ff, 1'b0)
        resume_seen_flag = 1'b0;
        resume_signal = 1'b0;
        rd(8'h01, 32'h0000_0040);
    endtask : check_wake_off
    task automatic check_overrun;
        repeat (5) begin
            periodic_overrun = 1'b1;
            @(negedge clk_sys);
            periodic_overrun = 1'b0;
            @(negedge clk_sys);
        end
        rd(8'h02, 32'h0001_0000);
        host.issue(8'h82, 32'hffff_fffe);
        rd(8'h02, 32'h0001_0000);
    endtask : check_overrun
    task automatic check_sw_reset;
        host.issue(8'h82, 32'h0000_0001);
        rd(8'h01, 32'h0000_0200);
        rd(8'h02, 32'h0);
        `CHK(root_hub_reset_ff, 1'b0)
        `CHK(port_reset_ff, 1'b0)
    endtask : check_sw_reset
    task automatic check_sof;
        int n;
        n = 0;
        host.issue(8'h81, 32'h0000_0080);
        while (frame_start_flag_ff !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(n, SOF)
        if (n == 100) print_verdict();
        `CHK(sof_enable_ff, 1'b1)
        @(negedge clk_sys);
        `CHK(frame_start_flag_ff, 1'b0)
        `CHK(sof_enable_ff, 1'b1)
        host.issue(8'h81, 32'h0);
        @(negedge clk_sys);
        `CHK(sof_enable_ff, 1'b0)
    endtask : check_sof
    initial begin
        do_reset();
        check_mode_write();
        check_resume();
        check_overrun();
        check_sw_reset();
        check_wake_off();
        check_sof();
        // Wake connected was set before; hardware reset must drop it
        check_mode_write();
        do_reset();
        print_verdict();
    end
endmodule : usb_host_control_command_regs_tb
